// >>> bench/qdac_host_model.sv
// Host model driving the four-wire serial link of the loader
module qdac_host_model (
    // Serial link towards the loader
    output logic link_sclk,
    output logic serial_data,
    output logic word_strobe,
    output logic output_update_strobe
);
    timeunit 1ns;
    timeprecision 1ns;

    // Idle link: clock parked low, strobes low
    initial
    begin
        link_sclk = 1'b0;
        serial_data = 1'b0;
        word_strobe = 1'b0;
        output_update_strobe = 1'b0;
    end

    // One frame MSB first at 32 ns, clock held low between bursts
    task automatic send_bits(input logic [31:0] bits, input int n, input int burst);
        word_strobe = 1'b1;
        #40;
        for (int i = n - 1; i >= 0; i--)
        begin
            serial_data = bits[i];
            #8 link_sclk = 1'b1;
            #16 link_sclk = 1'b0;
            #8;
            if (burst > 0 && i > 0 && (n - i) % burst == 0)
                #300;
        end
        // Released data line must not keep a stale value
        serial_data = ~serial_data;
        #40 word_strobe = 1'b0;
        // Stray clock pulse with the strobe low must not shift anything
        #400 link_sclk = 1'b1;
        #16 link_sclk = 1'b0;
        #184;
    endtask

    // Update strobe level, then room for the synchronisers
    task automatic set_update(input logic level);
        output_update_strobe = level;
        #600;
    endtask
endmodule // qdac_host_model

// >>> bench/qdac_loader_tb_top.sv
// Self-checking bench of the quad converter loader
module qdac_loader_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import qdac_pkg::*;

    // Bench signals and expectations
    logic        clk_sys;
    logic        resetn;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [31:0] reg_rdata;
    logic        link_sclk;
    logic        serial_data;
    logic        word_strobe;
    logic        output_update_strobe;
    qdac_bank_t  ch_out;
    qdac_bank_t  exp_in;
    qdac_bank_t  exp_app;
    qdac_word_t  last;
    logic [3:0]  pend;
    logic [7:0]  nload;
    logic        en;
    int          errors;
    int          n_tests;
    int          seed;

    qdac_loader dut (
        .clk_sys(clk_sys), .resetn(resetn),
        .link_sclk(link_sclk), .serial_data(serial_data),
        .word_strobe(word_strobe), .output_update_strobe(output_update_strobe),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .channel_a_output(ch_out[0]), .channel_b_output(ch_out[1]),
        .channel_c_output(ch_out[2]), .channel_d_output(ch_out[3])
    );

    qdac_host_model host (
        .link_sclk(link_sclk), .serial_data(serial_data),
        .word_strobe(word_strobe), .output_update_strobe(output_update_strobe)
    );

    // 10 MHz system clock
    always #50 clk_sys = ~clk_sys;

    task automatic conclude;
        $display("checks %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so sample mid-cycle
    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #50 d = reg_rdata;
    endtask

    // Frame with random leading junk; expectation follows the decode
    task automatic load(input qdac_word_t w, input int extra, input int burst);
        logic [31:0] bits;
        int          ch;
        bits = 32'($random(seed));
        bits[10:0] = w;
        ch = int'({w.channel_select_high, w.channel_select_low});
        host.send_bits(bits, 11 + extra, burst);
        if (en)
        begin
            exp_in[ch] = {w.gain_double_bit, w.code};
            nload++;
            last = w;
            if (output_update_strobe)
                pend[ch] = 1'b1;
            else
                exp_app[ch] = exp_in[ch];
        end
    endtask

    task automatic check_outputs;
        logic [31:0] d;
        for (int c = 0; c < 4; c++)
        begin
            check(32'(ch_out[c]), 32'(exp_app[c]));
            reg_read(8'h10 + 8'(4 * c), d);
            check(d, 32'(exp_app[c]));
            reg_read(8'h20 + 8'(4 * c), d);
            check(d, 32'(exp_in[c]));
        end
    endtask

    task automatic check_status;
        logic [31:0] d;
        reg_read(8'h04, d);
        check(d & 32'h0000_ff3f, {16'h0000, nload, 3'b000, output_update_strobe, pend});
        reg_read(8'h08, d);
        check(d, 32'(last));
    endtask

    // Main sequence
    initial
    begin
        logic [31:0] d;
        clk_sys = 1'b0;
        resetn = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0000_0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        exp_in = '0;
        exp_app = '0;
        last = '0;
        pend = 4'h0;
        nload = 8'h00;
        en = 1'b1;
        errors = 0;
        n_tests = 0;
        seed = 32'hb752;
        repeat (6) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (4) @(posedge clk_sys);
        check_outputs;
        check_status;
        // Codes ff, 7f, 3f and 1f on channels A to D, both ranges
        for (int c = 0; c < 4; c++)
            load({2'(c), c[0], 8'hff >> c}, 0, 0);
        check_outputs;
        // Random words, 0 to 7 leading junk bits, eight-bit bursts on odd passes
        for (int i = 0; i < 8; i++)
        begin
            load(11'($random(seed)), i, (i % 2) * 8);
            check_outputs;
        end
        // Held update, then one low pulse moves every channel
        host.set_update(1'b1);
        for (int i = 0; i < 4; i++)
            load(11'($random(seed)), 0, 8);
        check_outputs;
        check_status;
        host.set_update(1'b0);
        exp_app = exp_in;
        pend = 4'h0;
        check_outputs;
        check_status;
        // Loads ignored while disabled
        reg_write(8'h00, 32'h0000_0000);
        en = 1'b0;
        load(11'($random(seed)), 0, 0);
        check_outputs;
        reg_write(8'h00, 32'h0000_0001);
        en = 1'b1;
        // Transfer by register, self-clearing bit, unmapped read
        host.set_update(1'b1);
        load(11'($random(seed)), 2, 0);
        load(11'($random(seed)), 0, 8);
        reg_write(8'h00, 32'h0000_0003);
        exp_app = exp_in;
        pend = 4'h0;
        repeat (2) @(posedge clk_sys);
        check_outputs;
        check_status;
        reg_read(8'h00, d);
        check(d, 32'h0000_0001);
        reg_read(8'h30, d);
        check(d, 32'h0000_0000);
        host.set_update(1'b0);
        conclude;
    end

    // Watchdog well beyond the expected run
    initial
    begin
        #1_000_000;
        errors++;
        conclude;
    end
endmodule // qdac_loader_tb_top

// >>> inc/qdac_cfg.svh
// Register map, field positions and reset values of the quad converter loader
`ifndef QDAC_CFG_SVH
`define QDAC_CFG_SVH
`define QDAC_ADDR_W        8
`define QDAC_DATA_W        32
`define QDAC_WORD_W        11
`define QDAC_OFS_CTRL      8'h00
`define QDAC_OFS_STAT      8'h04
`define QDAC_OFS_WORD      8'h08
`define QDAC_OFS_APPL      4'h1
`define QDAC_OFS_INLT      4'h2
`define QDAC_CTRL_EN_BIT   0
`define QDAC_CTRL_XFER_BIT 1
`define QDAC_CTRL_RST      1'b1
`define QDAC_STAT_UPD_BIT  4
`define QDAC_STAT_LOAD_BIT 5
`define QDAC_STAT_CNT_LSB  8
`endif

// >>> inc/qdac_pkg.sv
// Types shared by the quad converter loader
package qdac_pkg;
    // Range bit and code as handed to one converter channel
    typedef struct packed {
        logic       gain_double_bit;
        logic [7:0] code;
    } qdac_chan_t;
    // Serial word, first bit shifted in sits at the top
    typedef struct packed {
        logic       channel_select_high;
        logic       channel_select_low;
        logic       gain_double_bit;
        logic [7:0] code;
    } qdac_word_t;
    typedef qdac_chan_t [3:0] qdac_bank_t;
endpackage

// >>> rtl/qdac_loader.sv
// Serial word loader and double-buffered code latches of a quad converter
//
// Summary of operation
// R1 - Words arrive MSB first: two select bits, range bit, eight code bits.
// R2 - While word strobe high, data is sampled on each falling serial clock.
// R3 - Any bit count is accepted; only the last eleven bits are kept.
// R4 - Falling word strobe stores range and code in addressed input latch.
// R5 - Select 0..3 addresses channels A, B, C and D.
// R6 - Update strobe low: applied latch follows the input latch on load.
// R7 - Update strobe high: load changes only the input latch.
// R8 - Falling update strobe copies all input latches to applied latches.
// R9 - After power up every applied code is zero.
// R10 - Range bit 0 means unity gain, 1 means doubled gain.
// R11 - Each channel presents its 8-bit code 0..255 to the core.
// R12 - Host writes several words with update high, then pulses update low.
// R13 - Bits accumulate across pauses with the serial clock held low.
// R14 - One word plus the word strobe updates one channel, update held low.
// R15 - Word and update strobes are synchronised before edge detection.
//
// Chosen here: the strobed register port and the address map.
`include "qdac_cfg.svh"

module qdac_loader #(
    parameter int ADDR_W = `QDAC_ADDR_W
) (
    // System clock and reset
    input  wire logic                    clk_sys,
    input  wire logic                    resetn,
    // Serial link from the host
    input  wire logic                    link_sclk,
    input  wire logic                    serial_data,
    input  wire logic                    word_strobe,
    input  wire logic                    output_update_strobe,
    // Register port
    input  wire logic [ADDR_W-1:0]       reg_addr,
    input  wire logic [`QDAC_DATA_W-1:0] reg_wdata,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    output logic      [`QDAC_DATA_W-1:0] reg_rdata,
    // Applied range and code per channel
    output qdac_pkg::qdac_chan_t         channel_a_output,
    output qdac_pkg::qdac_chan_t         channel_b_output,
    output qdac_pkg::qdac_chan_t         channel_c_output,
    output qdac_pkg::qdac_chan_t         channel_d_output
);
    import qdac_pkg::*;

    // Link domain
    logic [`QDAC_WORD_W-1:0] shift_reg;

    // Strobe synchronisers
    logic       load_s1_reg;
    logic       load_s2_reg;
    logic       load_s3_reg;
    logic       upd_s1_reg;
    logic       upd_s2_reg;
    logic       upd_s3_reg;
    logic       load_evt;
    logic       upd_fall;

    // Latches and control
    qdac_word_t word;
    qdac_chan_t word_chan;
    logic [1:0] word_sel;
    qdac_bank_t in_latch_reg;
    qdac_bank_t in_latch_next;
    qdac_bank_t applied_reg;
    logic       enable_reg;
    logic       force_xfer;
    logic       xfer_all;
    logic       load_take;
    logic [`QDAC_WORD_W-1:0] last_word_reg;
    logic [3:0] pending_reg;
    logic [7:0] load_cnt_reg;
    logic [`QDAC_DATA_W-1:0] rdata_next;

    // Shift register on the falling serial clock. Data and word strobe are
    // launched by the host against this clock, so they need no synchroniser.
    always_ff @(negedge link_sclk or negedge resetn)
    begin
        if (!resetn)
        begin
            shift_reg <= '0;
        end
        else if (word_strobe) // R2
        begin
            // Oldest bits fall off the top, only eleven survive
            shift_reg <= {shift_reg[`QDAC_WORD_W-2:0], serial_data}; // R3 R13
        end
    end

    // Word strobe synchroniser, third stage only for edge detection
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            load_s1_reg <= 1'b0;
            load_s2_reg <= 1'b0;
            load_s3_reg <= 1'b0;
        end
        else
        begin
            load_s1_reg <= word_strobe; // R15
            load_s2_reg <= load_s1_reg;
            load_s3_reg <= load_s2_reg;
        end
    end

    // Update strobe synchroniser; reset low like the idle pin, so no false fall
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            upd_s1_reg <= 1'b0;
            upd_s2_reg <= 1'b0;
            upd_s3_reg <= 1'b0;
        end
        else
        begin
            upd_s1_reg <= output_update_strobe; // R15
            upd_s2_reg <= upd_s1_reg;
            upd_s3_reg <= upd_s2_reg;
        end
    end

    // Falling edges of both strobes
    assign load_evt = load_s3_reg & ~load_s2_reg; // R15
    assign upd_fall = upd_s3_reg & ~upd_s2_reg;   // R15

    // The shift register is frozen while the strobe is low, and the fall
    // reaches this domain two edges late, so the word is settled here.
    assign word      = qdac_word_t'(shift_reg); // R1
    assign word_sel  = {word.channel_select_high, word.channel_select_low};
    assign word_chan = '{gain_double_bit: word.gain_double_bit, code: word.code};
    assign load_take = load_evt & enable_reg;

    // Software transfer request and combined transfer
    assign force_xfer = reg_wr && (reg_addr == `QDAC_OFS_CTRL)
                        && reg_wdata[`QDAC_CTRL_XFER_BIT];
    assign xfer_all   = upd_fall | force_xfer;

    // Input latch next value: addressed channel only
    always_comb
    begin
        in_latch_next = in_latch_reg;
        if (load_take)
        begin
            in_latch_next[word_sel] = word_chan; // R4 R5
        end
    end

    // Input latches
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            in_latch_reg <= '0;
        end
        else
        begin
            in_latch_reg <= in_latch_next; // R4
        end
    end

    // Second latches. A transfer takes the freshly loaded input latch too,
    // so a load and an update edge in one cycle lose nothing.
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            applied_reg <= '0; // R9
        end
        else if (xfer_all)
        begin
            applied_reg <= in_latch_next; // R8 R12
        end
        else if (load_take && !upd_s2_reg)
        begin
            applied_reg[word_sel] <= word_chan; // R6 R14
        end
    end

    // Channels waiting for a transfer; the clear wins over a load in the same cycle
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            pending_reg <= 4'h0;
        end
        else
        begin
            if (xfer_all)
            begin
                pending_reg <= 4'h0;
            end
            if (load_take && upd_s2_reg && !xfer_all)
            begin
                pending_reg[word_sel] <= 1'b1; // R7
            end
        end
    end

    // Last word and load counter for software
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            last_word_reg <= '0;
            load_cnt_reg  <= 8'h00;
        end
        else if (load_take)
        begin
            last_word_reg <= shift_reg;
            load_cnt_reg  <= load_cnt_reg + 8'h01;
        end
    end

    // Control register: loads may be gated off by software
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            enable_reg <= `QDAC_CTRL_RST;
        end
        else if (reg_wr && (reg_addr == `QDAC_OFS_CTRL))
        begin
            enable_reg <= reg_wdata[`QDAC_CTRL_EN_BIT];
        end
    end

    // Read decode; unmapped addresses read zero
    always_comb
    begin
        rdata_next = '0;
        if (reg_addr == `QDAC_OFS_CTRL)
        begin
            rdata_next[`QDAC_CTRL_EN_BIT] = enable_reg;
        end
        else if (reg_addr == `QDAC_OFS_STAT)
        begin
            rdata_next[3:0]                     = pending_reg;
            rdata_next[`QDAC_STAT_UPD_BIT]      = upd_s2_reg;
            rdata_next[`QDAC_STAT_LOAD_BIT]     = load_s2_reg;
            rdata_next[`QDAC_STAT_CNT_LSB +: 8] = load_cnt_reg;
        end
        else if (reg_addr == `QDAC_OFS_WORD)
        begin
            rdata_next[`QDAC_WORD_W-1:0] = last_word_reg;
        end
        else if (reg_addr[7:4] == `QDAC_OFS_APPL && reg_addr[1:0] == 2'b00)
        begin
            rdata_next[8:0] = applied_reg[reg_addr[3:2]];
        end
        else if (reg_addr[7:4] == `QDAC_OFS_INLT && reg_addr[1:0] == 2'b00)
        begin
            rdata_next[8:0] = in_latch_reg[reg_addr[3:2]];
        end
    end

    // Read data stands only in the cycle after the read strobe
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            reg_rdata <= '0;
        end
        else if (reg_rd)
        begin
            reg_rdata <= rdata_next;
        end
        else
        begin
            reg_rdata <= '0;
        end
    end

    // Channel outputs straight from the second latches; range bit picks
    // the gain in the amplifier, the code drives the resistor string.
    assign channel_a_output = applied_reg[0]; // R10 R11
    assign channel_b_output = applied_reg[1]; // R10 R11
    assign channel_c_output = applied_reg[2]; // R10 R11
    assign channel_d_output = applied_reg[3]; // R10 R11

    // Checks in the system domain
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);

    // Load stores the word in the addressed input latch
    chk_load_latch: assert property ( // R4
        load_take |=> in_latch_reg[$past(word_sel)] == $past(word_chan))
        else $error("input latch missed the loaded word");

    // Selects 0 and 3 change only the addressed channel's input latch
    chk_decode_chan_a: assert property ( // R5
        load_take && word_sel == 2'd0
        |=> in_latch_reg[3:1] == $past(in_latch_reg[3:1])
            && in_latch_reg[0] == $past(word_chan))
        else $error("select 0 touched a channel other than A");

    chk_decode_chan_d: assert property ( // R5
        load_take && word_sel == 2'd3
        |=> in_latch_reg[2:0] == $past(in_latch_reg[2:0]))
        else $error("select 3 touched a channel other than D");

    // Transparent second latch follows the load
    chk_transparent_apply: assert property ( // R6
        load_take && !upd_s2_reg |=> applied_reg[$past(word_sel)] == $past(word_chan))
        else $error("applied code not updated with update strobe low");

    // Held update strobe keeps applied codes
    chk_held_apply: assert property ( // R7
        load_take && upd_s2_reg && !xfer_all |=> $stable(applied_reg))
        else $error("applied code changed while update strobe high");

    // Update edge transfers every channel
    chk_update_all: assert property ( // R8
        output_update_strobe ##1 !output_update_strobe [*3] ##0 !load_take
        |=> applied_reg == $past(in_latch_reg))
        else $error("update edge did not transfer all input latches");

    // Nothing loaded yet means all applied codes still zero
    chk_reset_zero: assert property ( // R9
        load_cnt_reg == 8'h00 |-> applied_reg == '0)
        else $error("applied code nonzero before any load");

    // Output channel C shows a word loaded for it with update strobe low
    chk_output_map: assert property ( // R11
        load_take && word_sel == 2'd2 && !upd_s2_reg
        |=> channel_c_output == $past(word_chan))
        else $error("channel C output differs from its loaded word");

    // Code taken from the low eight bits, select from the top two
    chk_word_order: assert property ( // R1
        load_take
        |=> in_latch_reg[$past(shift_reg[10:9])].code == $past(shift_reg[7:0]))
        else $error("code not taken from the last eight bits");

    // Range bit taken from the third bit shifted in
    chk_gain_bit: assert property ( // R10
        load_take && !upd_s2_reg
        |=> applied_reg[$past(shift_reg[10:9])].gain_double_bit == $past(shift_reg[8]))
        else $error("applied range bit differs from the word");

    // A single word with select 1 moves only applied channel B
    chk_single_update: assert property ( // R14
        load_take && word_sel == 2'd1 && !upd_s2_reg && !xfer_all
        |=> applied_reg[1] == $past(word_chan)
            && applied_reg[0] == $past(applied_reg[0])
            && applied_reg[3:2] == $past(applied_reg[3:2]))
        else $error("single word update touched another channel");

    // A held load is remembered as waiting for a transfer
    chk_held_pending: assert property ( // R7
        load_take && upd_s2_reg && !xfer_all |=> pending_reg[$past(word_sel)])
        else $error("held load not marked as pending");

    // A transfer leaves nothing waiting
    chk_pending_clear: assert property ( // R8
        xfer_all |=> pending_reg == 4'h0)
        else $error("pending channels left after a transfer");

    // Strobe falls are ignored while loads are gated off
    chk_disabled_load: assert property ( // R4
        load_evt && !enable_reg && !xfer_all |=> $stable(in_latch_reg))
        else $error("input latch changed while loads were disabled");

    // Shift register in the link domain
    chk_keep_eleven: assert property ( // R3
        @(negedge link_sclk) disable iff (!resetn)
        word_strobe |=> shift_reg[`QDAC_WORD_W-1:1] == $past(shift_reg[`QDAC_WORD_W-2:0]))
        else $error("shift register did not move by one bit");

    chk_shift_in: assert property ( // R2
        @(negedge link_sclk) disable iff (!resetn)
        word_strobe |=> shift_reg[0] == $past(serial_data))
        else $error("serial data bit not captured");

    chk_shift_hold: assert property ( // R13
        @(negedge link_sclk) disable iff (!resetn)
        !word_strobe |=> $stable(shift_reg))
        else $error("shift register moved with word strobe low");

    // Main scenarios
    cov_single_load: cover property (load_take && !upd_s2_reg);
    cov_held_load:   cover property (load_take && upd_s2_reg);
    cov_update_edge: cover property (upd_fall && pending_reg != 4'h0);
    cov_soft_xfer:   cover property (force_xfer);

endmodule // qdac_loader
